// ---- design/reset_source_combiner.sv ----
`timescale 1ns/10ps
`default_nettype none
module reset_source_combiner (
  input wire logic clk,
  input wire logic rst_n,
  input wire reset_combiner_pkg::sources_s sources,
  input wire logic [reset_combiner_pkg::ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  output logic master_system_reset,
  output logic master_system_reset_n
);

  // ==========================================================
  // Source synchronisation
  reset_combiner_pkg::sources_s src_sync;
  logic [8:0] src_raw;

  reset_sync #(
    .WIDTH(9)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(sources),
    .sync_out(src_raw)
  );

  assign src_sync = reset_combiner_pkg::sources_s'(src_raw);

  // ==========================================================
  // Combining
  logic any_src;
  logic sys_rst_q;

  // Pure OR; software flag writes never reach here
  assign any_src = |src_raw;

  // Registered so the reset has no glitches toward the CPU
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_rst_q <= 1'b1;
    end else begin
      sys_rst_q <= any_src;
    end
  end

  assign master_system_reset = sys_rst_q;
  assign master_system_reset_n = ~sys_rst_q;

  // ==========================================================
  // Cause register
  function automatic logic [15:0] cause_set(
    input reset_combiner_pkg::sources_s s
  );
    logic [15:0] v;
    v = 16'h0000;
    v[reset_combiner_pkg::PIN_BIT] = s.external_pin;
    v[reset_combiner_pkg::INSTR_BIT] = s.instruction;
    v[reset_combiner_pkg::WDOG_BIT] = s.watchdog;
    v[reset_combiner_pkg::BROWNOUT_BIT] = s.brownout;
    v[reset_combiner_pkg::CFG_BIT] = s.config_mismatch;
    v[reset_combiner_pkg::TRAP_BIT] = s.trap_conflict;
    v[reset_combiner_pkg::ILLOP_BIT] = s.illegal_op | s.uninit_wreg;
    return v;
  endfunction

  logic [15:0] reset_cause_register_q;
  logic [15:0] cause_d;
  logic cause_wr;

  assign cause_wr = wr_en && (addr == reset_combiner_pkg::CAUSE_ADDR);

  always_comb begin
    cause_d = reset_cause_register_q;
    if (cause_wr) begin
      cause_d = wdata & reset_combiner_pkg::CAUSE_MASK;
    end
    // Hardware set wins over a simultaneous software clear
    cause_d = cause_d | cause_set(src_sync);
    if (src_sync.power_on) begin
      cause_d = reset_combiner_pkg::CAUSE_POR_VAL;
    end
  end

  // rst_n and power_on load CAUSE_POR_VAL, software writes can clear; other source resets merely OR in flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_cause_register_q <= reset_combiner_pkg::CAUSE_POR_VAL;
    end else begin
      reset_cause_register_q <= cause_d;
    end
  end

  // ==========================================================
  // Read port
  logic [15:0] rdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (rd_en) begin
      unique case (addr)
        reset_combiner_pkg::CAUSE_ADDR: rdata_q <= reset_cause_register_q;
        reset_combiner_pkg::ACTIVE_ADDR: rdata_q <= {7'h00, src_raw};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata = rdata_q;

  // Downstream logic uses master_system_reset for its defined values
  // software is expected to clear flags after reading

  // ==========================================================
  // Checks
  chk_or_combine: assert property (@(posedge clk) disable iff (!rst_n)
    (|src_raw) |=> master_system_reset)
    else $error("reset not asserted for active source");
  chk_no_spurious: assert property (@(posedge clk) disable iff (!rst_n)
    !(|src_raw) |=> !master_system_reset)
    else $error("reset without active source");
  chk_por_value: assert property (@(posedge clk) disable iff (!rst_n)
    src_sync.power_on
      |=> reset_cause_register_q == reset_combiner_pkg::CAUSE_POR_VAL)
    else $error("power-on cause value wrong");
  chk_cfg_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (src_sync.config_mismatch && !src_sync.power_on)
      |=> reset_cause_register_q[9])
    else $error("config mismatch flag not set");
  chk_trap_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (src_sync.trap_conflict && !src_sync.power_on)
      |=> reset_cause_register_q[15])
    else $error("trap flag not set");
  chk_illop_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ((src_sync.illegal_op || src_sync.uninit_wreg) && !src_sync.power_on)
      |=> reset_cause_register_q[14])
    else $error("illegal op flag not set");
  chk_pin_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (src_sync.external_pin && !src_sync.power_on)
      |=> reset_cause_register_q[7])
    else $error("pin flag not set");
  chk_flag_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!cause_wr && !src_sync.power_on)
      |=> (reset_cause_register_q & $past(reset_cause_register_q))
          == $past(reset_cause_register_q))
    else $error("cause flag lost");
  chk_sw_write: assert property (@(posedge clk) disable iff (!rst_n)
    (cause_wr && !(|src_raw))
      |=> reset_cause_register_q
          == ($past(wdata) & reset_combiner_pkg::CAUSE_MASK))
    else $error("software write not stored");

  cov_por: cover property (@(posedge clk) disable iff (!rst_n)
    src_sync.power_on);
  cov_wdog: cover property (@(posedge clk) disable iff (!rst_n)
    src_sync.watchdog && !src_sync.power_on);
  cov_sw_clear: cover property (@(posedge clk) disable iff (!rst_n)
    cause_wr && wdata == 16'h0000);
  cov_set_vs_clear: cover property (@(posedge clk) disable iff (!rst_n)
    cause_wr && (|src_raw));

endmodule
`default_nettype wire

// ---- design/reset_combiner_pkg.sv ----
package reset_combiner_pkg;

  // ==========================================================
  // Cause register layout
  localparam int unsigned CAUSE_W = 16;
  localparam int unsigned POR_BIT = 0;
  localparam int unsigned BROWNOUT_BIT = 1;
  localparam int unsigned INSTR_BIT = 6;
  localparam int unsigned PIN_BIT = 7;
  localparam int unsigned WDOG_BIT = 4;
  localparam int unsigned CFG_BIT = 9;
  localparam int unsigned ILLOP_BIT = 14;
  localparam int unsigned TRAP_BIT = 15;

  // Implemented cause bits; the rest read as zero
  localparam logic [15:0] CAUSE_MASK = 16'hC2D3;
  localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;

  // ==========================================================
  // Register port
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] CAUSE_ADDR = 4'h0;
  localparam logic [3:0] ACTIVE_ADDR = 4'h1;

  // Nine reset sources
  typedef struct packed {
    logic uninit_wreg;
    logic illegal_op;
    logic trap_conflict;
    logic config_mismatch;
    logic brownout;
    logic watchdog;
    logic instruction;
    logic external_pin;
    logic power_on;
  } sources_s;

endpackage

// ---- design/reset_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module reset_sync #(
  parameter int unsigned WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ==========================================================
  // Two-stage synchroniser; stage one is read only by stage two
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// ---- bench/reset_source_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// On-chip reset detectors seen from the combiner
module reset_source_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [8:0] fire,
  output var reset_combiner_pkg::sources_s sources
);
  // Detectors raise levels just after an edge, never mid-cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sources <= '0;
    end else begin
      sources <= fire;
    end
  end
endmodule
`default_nettype wire

// ---- bench/reset_source_combiner_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench
module reset_source_combiner_bench;
  logic clk, rst_n, wr_en, rd_en, msr, msr_n;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, exp_v;
  logic [8:0] fire;
  reset_combiner_pkg::sources_s sources;
  int n_fail = 0;
  int total_checks = 0;
  // Cause bit per source, power-on first
  logic [15:0] bitmap [0:8] = '{16'h0003, 16'h0080, 16'h0040, 16'h0010,
    16'h0002, 16'h0200, 16'h8000, 16'h4000, 16'h4000};

  reset_source_combiner DUT (.clk(clk), .rst_n(rst_n), .sources(sources),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .master_system_reset(msr),
    .master_system_reset_n(msr_n));
  reset_source_model model (.clk(clk), .rst_n(rst_n), .fire(fire),
    .sources(sources));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 check("rdata", rdata, exp);
  endtask

  // Latency is 1 model flop plus 3 in the combiner; 6 leaves margin
  task automatic settle(input logic [8:0] f);
    @(posedge clk);
    fire <= f;
    repeat (6) @(posedge clk);
    #1;
  endtask

  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    fire = 9'h000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    settle(9'h000);
    check("msr", {15'h0000, msr}, 16'h0000);
    rd(4'h0, 16'h0003);
    wr(4'h0, 16'hFFFF);
    settle(9'h000);
    check("msr", {15'h0000, msr}, 16'h0000);
    rd(4'h0, 16'hC2D3);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000);
    wr(4'hF, 16'hFFFF);
    rd(4'hF, 16'h0000);
    rd(4'h0, 16'h0000);
    exp_v = 16'h0000;
    for (int i = 1; i < 9; i++) begin
      settle(9'h001 << i);
      check("msr", {15'h0000, msr}, 16'h0001);
      check("msr_n", {15'h0000, msr_n}, 16'h0000);
      rd(4'h1, 16'h0001 << i);
      exp_v = exp_v | bitmap[i];
      rd(4'h0, exp_v);
      settle(9'h000);
      check("msr", {15'h0000, msr}, 16'h0000);
      rd(4'h0, exp_v);
    end
    settle(9'h001);
    check("msr", {15'h0000, msr}, 16'h0001);
    rd(4'h0, 16'h0003);
    settle(9'h000);
    rd(4'h0, 16'h0003);
    final_report();
  end

  // A hang counts as a mismatch
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire
